/* File: core/pepw_pkg.sv */
// Package: constants and types of the parallel EEPROM page write host controller
package pepw_pkg;
	localparam int unsigned CLK_MHZ        = 125;
	localparam int unsigned ADDR_W         = 13;
	localparam int unsigned DATA_W         = 8;
	localparam int unsigned ARRAY_DEPTH    = 8192;
	localparam int unsigned PAGE_BYTES     = 32;
	localparam int unsigned PAGE_LSB       = 5;
	localparam int unsigned POLL_BIT       = 7;
	// Strobe timing in ns, and cycle counts derived from the clock rate
	localparam int unsigned WP_MIN_NS      = 100;
	localparam int unsigned WP_MAX_NS      = 1000;
	localparam int unsigned WPH_MIN_NS     = 50;
	localparam int unsigned ACC_MAX_NS     = 120;
	localparam int unsigned WP_CYC         = (WP_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned WP_MAX_CYC     = (WP_MAX_NS * CLK_MHZ) / 1000;
	localparam int unsigned WPH_CYC        = (WPH_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned ACC_CYC        = (ACC_MAX_NS * CLK_MHZ + 999) / 1000 + 2;
	// Long times in us / ms, turned into default cycle counts below
	localparam int unsigned PLW_MAX_US     = 150;
	localparam int unsigned WC_MAX_MS      = 2;
	localparam int unsigned PWRUP_MS       = 5;
	localparam int unsigned CLEAR_MS       = 10;
	localparam int unsigned PLW_CYC_DEF    = PLW_MAX_US * CLK_MHZ;
	localparam int unsigned WC_CYC_DEF     = WC_MAX_MS * 1000 * CLK_MHZ;
	localparam int unsigned PWRUP_CYC_DEF  = PWRUP_MS * 1000 * CLK_MHZ;
	localparam int unsigned CLEAR_CYC_DEF  = CLEAR_MS * 1000 * CLK_MHZ;
	localparam int unsigned CNT_W          = 24;
	localparam logic [ADDR_W-1:0] ID_BASE  = 13'h1FE0;

	// Commands from the user port
	typedef enum logic [1:0] {PEPW_CMD_READ, PEPW_CMD_PAGE, PEPW_CMD_CLEAR} pepw_cmd_t;

	// One user request
	typedef struct packed {
		pepw_cmd_t           cmd;
		logic                id_space;
		logic [ADDR_W-1:0]   addr;
		logic [5:0]          count;
	} pepw_req_t;

	// Pin drive group
	typedef struct packed {
		logic                cs_n;
		logic                oe_n;
		logic                we_n;
		logic                oe_hv;
		logic                id_hv;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   dout;
		logic                doe;
	} pepw_pins_t;
endpackage : pepw_pkg

/* File: core/pepw_host.sv */
// Host controller that reads, page-writes and clears an 8K x 8 parallel EEPROM
// How it works
// - Write pulses strobe with select low, OE high.
// - All loads within 150 us of first.
// - Page address held fixed during loads.
// - Next access after a page write only after polling completes or times out; a clear goes straight back to idle.
// - Clear: OE high voltage, 10 ms strobe.
// - Id space raises id line high voltage.
module pepw_host
	import pepw_pkg::*;
#(
	parameter int unsigned PLW_CYC   = PLW_CYC_DEF,
	parameter int unsigned WC_CYC    = WC_CYC_DEF,
	parameter int unsigned PWRUP_CYC = PWRUP_CYC_DEF,
	parameter int unsigned CLEAR_CYC = CLEAR_CYC_DEF
) (
	input  wire logic              SYS_CLK,
	input  wire logic              RST,
	input  wire pepw_req_t         REQ,
	input  wire logic              REQ_VALID,
	output logic                   REQ_READY,
	input  wire logic [DATA_W-1:0] WDATA,
	input  wire logic [4:0]        WBYTE,
	input  wire logic              WDATA_VALID,
	output logic                   WDATA_READY,
	output logic [DATA_W-1:0]      RDATA,
	output logic                   RDATA_VALID,
	output logic                   DONE,
	output logic                   TIMEOUT,
	output logic                   CS_N,
	output logic                   OE_N,
	output logic                   WE_N,
	output logic                   OE_HV,
	output logic                   ID_HV,
	output logic [ADDR_W-1:0]      ADDRESS_LINES,
	output logic [DATA_W-1:0]      DATA_PINS_O,
	output logic                   DATA_PINS_OE,
	input  wire logic [DATA_W-1:0] DATA_PINS_I
);
	typedef enum {S_LOCK, S_IDLE, S_RD, S_LD_WAIT, S_LD_SET, S_LD_LOW, S_LD_HIGH,
		S_PL_SET, S_PL_RD, S_PL_GAP, S_CL_SET, S_CL_LOW, S_CL_HOLD} pepw_state_t;

	pepw_state_t            state_ff;
	pepw_pins_t             pins_ff;
	logic [CNT_W-1:0]       tmr_ff;
	logic [CNT_W-1:0]       plw_ff;
	logic [CNT_W-1:0]       wc_ff;
	logic [5:0]             left_ff;
	logic [DATA_W-1:0]      last_ff;
	logic [ADDR_W-1:0]      base_ff;
	logic [DATA_W-1:0]      sync1_ff;
	logic [DATA_W-1:0]      sync2_ff;
	logic                   req_rdy_ff;
	logic                   wd_rdy_ff;
	logic [DATA_W-1:0]      rdata_ff;
	logic                   rvalid_ff;
	logic                   done_ff;
	logic                   tout_ff;
	logic                   tmr_zero;
	logic                   loaded_ff;

	assign tmr_zero = (tmr_ff == '0);

	// Two-stage synchroniser on the data pins
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= DATA_PINS_I;
			sync2_ff <= sync1_ff;
		end
	end

	// Main sequencer for pins and handshakes
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			state_ff   <= S_LOCK;
			pins_ff    <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, oe_hv: 1'b0, id_hv: 1'b0,
				addr: '0, dout: '0, doe: 1'b0};
			tmr_ff     <= CNT_W'(PWRUP_CYC);
			plw_ff     <= '0;
			wc_ff      <= '0;
			left_ff    <= '0;
			last_ff    <= '0;
			base_ff    <= '0;
			req_rdy_ff <= 1'b0;
			wd_rdy_ff  <= 1'b0;
			rdata_ff   <= '0;
			rvalid_ff  <= 1'b0;
			done_ff    <= 1'b0;
			tout_ff    <= 1'b0;
			loaded_ff  <= 1'b0;
		end else begin
			rvalid_ff <= 1'b0;
			done_ff   <= 1'b0;
			tout_ff   <= 1'b0;
			if (!tmr_zero) begin
				tmr_ff <= tmr_ff - 1'b1;
			end
			if (plw_ff != '0) begin
				plw_ff <= plw_ff - 1'b1;
			end
			if (wc_ff != '0) begin
				wc_ff <= wc_ff - 1'b1;
			end
			case (state_ff)
				S_LOCK: begin
					if (tmr_zero) begin
						state_ff   <= S_IDLE;
						req_rdy_ff <= 1'b1;
					end
				end
				S_IDLE: begin
					if (REQ_VALID && req_rdy_ff) begin
						req_rdy_ff    <= 1'b0;
						pins_ff.id_hv <= REQ.id_space;
						pins_ff.addr  <= REQ.id_space ? (ID_BASE | REQ.addr) : REQ.addr;
						base_ff       <= REQ.id_space ? (ID_BASE | REQ.addr) : REQ.addr;
						case (REQ.cmd)
							PEPW_CMD_READ: begin
								pins_ff.cs_n <= 1'b0;
								pins_ff.oe_n <= 1'b0;
								tmr_ff       <= CNT_W'(ACC_CYC);
								state_ff     <= S_RD;
							end
							PEPW_CMD_PAGE: begin
								// Clamp count to one..32 loads
								left_ff   <= (REQ.count == '0) ? 6'h01 :
									(REQ.count > 6'(PAGE_BYTES)) ? 6'(PAGE_BYTES) : REQ.count;
								wd_rdy_ff <= 1'b1;
								state_ff  <= S_LD_WAIT;
							end
							PEPW_CMD_CLEAR: begin
								pins_ff.cs_n  <= 1'b0;
								pins_ff.oe_hv <= 1'b1;
								tmr_ff        <= CNT_W'(WP_CYC);
								state_ff      <= S_CL_SET;
							end
							default: begin
								req_rdy_ff <= 1'b1;
							end
						endcase
					end
				end
				S_RD: begin
					if (tmr_zero) begin
						rdata_ff     <= sync2_ff;
						rvalid_ff    <= 1'b1;
						pins_ff.cs_n <= 1'b1;
						pins_ff.oe_n <= 1'b1;
						pins_ff.id_hv <= 1'b0;
						req_rdy_ff   <= 1'b1;
						state_ff     <= S_IDLE;
					end
				end
				S_LD_WAIT: begin
					// Load window closing: stop loading, go polling
					if (loaded_ff && plw_ff <= CNT_W'(WP_CYC + WPH_CYC)) begin
						wd_rdy_ff <= 1'b0;
						wc_ff     <= CNT_W'(WC_CYC);
						state_ff  <= S_PL_SET;
					end else if (WDATA_VALID && wd_rdy_ff) begin
						wd_rdy_ff <= 1'b0;
						// Page bits stay, byte bits from user
						pins_ff.addr <= {base_ff[ADDR_W-1:PAGE_LSB], WBYTE};
						pins_ff.dout <= WDATA;
						pins_ff.doe  <= 1'b1;
						pins_ff.cs_n <= 1'b0;
						pins_ff.oe_n <= 1'b1;
						last_ff      <= WDATA;
						tmr_ff       <= CNT_W'(1);
						state_ff     <= S_LD_SET;
					end
				end
				S_LD_SET: begin
					if (tmr_zero) begin
						pins_ff.we_n <= 1'b0;
						tmr_ff       <= CNT_W'(WP_CYC);
						if (!loaded_ff) begin
							plw_ff    <= CNT_W'(PLW_CYC);
							loaded_ff <= 1'b1;
						end
						state_ff <= S_LD_LOW;
					end
				end
				S_LD_LOW: begin
					if (tmr_zero) begin
						pins_ff.we_n <= 1'b1;
						tmr_ff       <= CNT_W'(WPH_CYC);
						left_ff      <= left_ff - 1'b1;
						state_ff     <= S_LD_HIGH;
					end
				end
				S_LD_HIGH: begin
					if (tmr_zero) begin
						pins_ff.doe  <= 1'b0;
						pins_ff.cs_n <= 1'b1;
						if (left_ff == '0) begin
							wc_ff    <= CNT_W'(WC_CYC);
							state_ff <= S_PL_SET;
						end else begin
							wd_rdy_ff <= 1'b1;
							state_ff  <= S_LD_WAIT;
						end
					end
				end
				S_PL_SET: begin
					loaded_ff    <= 1'b0;
					pins_ff.cs_n <= 1'b0;
					pins_ff.oe_n <= 1'b0;
					tmr_ff       <= CNT_W'(ACC_CYC);
					state_ff     <= S_PL_RD;
				end
				S_PL_RD: begin
					if (tmr_zero) begin
						pins_ff.cs_n <= 1'b1;
						pins_ff.oe_n <= 1'b1;
						if (sync2_ff[POLL_BIT] == last_ff[POLL_BIT] || wc_ff == '0) begin
							done_ff       <= 1'b1;
							tout_ff       <= (sync2_ff[POLL_BIT] != last_ff[POLL_BIT]);
							pins_ff.id_hv <= 1'b0;
							req_rdy_ff    <= 1'b1;
							state_ff      <= S_IDLE;
						end else begin
							tmr_ff   <= CNT_W'(WPH_CYC);
							state_ff <= S_PL_GAP;
						end
					end
				end
				S_PL_GAP: begin
					if (tmr_zero) begin
						state_ff <= S_PL_SET;
					end
				end
				S_CL_SET: begin
					if (tmr_zero) begin
						pins_ff.we_n <= 1'b0;
						tmr_ff       <= CNT_W'(CLEAR_CYC);
						state_ff     <= S_CL_LOW;
					end
				end
				S_CL_LOW: begin
					if (tmr_zero) begin
						pins_ff.we_n <= 1'b1;
						tmr_ff       <= CNT_W'(WP_CYC);
						state_ff     <= S_CL_HOLD;
					end
				end
				S_CL_HOLD: begin
					if (tmr_zero) begin
						pins_ff.oe_hv <= 1'b0;
						pins_ff.cs_n  <= 1'b1;
						done_ff       <= 1'b1;
						req_rdy_ff    <= 1'b1;
						state_ff      <= S_IDLE;
					end
				end
				default: begin
					state_ff <= S_LOCK;
				end
			endcase
		end
	end

	// Outputs straight from flip-flops
	assign REQ_READY     = req_rdy_ff;
	assign WDATA_READY   = wd_rdy_ff;
	assign RDATA         = rdata_ff;
	assign RDATA_VALID   = rvalid_ff;
	assign DONE          = done_ff;
	assign TIMEOUT       = tout_ff;
	assign CS_N          = pins_ff.cs_n;
	assign OE_N          = pins_ff.oe_n;
	assign WE_N          = pins_ff.we_n;
	assign OE_HV         = pins_ff.oe_hv;
	assign ID_HV         = pins_ff.id_hv;
	assign ADDRESS_LINES = pins_ff.addr;
	assign DATA_PINS_O   = pins_ff.dout;
	assign DATA_PINS_OE  = pins_ff.doe;
endmodule : pepw_host

/* File: verification/pepw_host_props.sv */
// Pin-side and status checks of the EEPROM host controller
module pepw_host_props
	import pepw_pkg::*;
#(
	parameter int unsigned PWRUP_CYC = PWRUP_CYC_DEF,
	parameter int unsigned CLEAR_CYC = CLEAR_CYC_DEF
) (
	input wire logic              SYS_CLK,
	input wire logic              RST,
	input wire logic              RDATA_VALID,
	input wire logic              DONE,
	input wire logic              TIMEOUT,
	input wire logic              CS_N,
	input wire logic              OE_N,
	input wire logic              WE_N,
	input wire logic              OE_HV,
	input wire logic              ID_HV,
	input wire logic [ADDR_W-1:0] ADDRESS_LINES,
	input wire logic [DATA_W-1:0] DATA_PINS_O,
	input wire logic              DATA_PINS_OE
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	logic [23:0] low_ff;
	logic [23:0] up_ff;
	// Cycles the strobe has been low
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			low_ff <= '0;
		end else if (WE_N) begin
			low_ff <= '0;
		end else begin
			low_ff <= low_ff + 24'h1;
		end
	end
	// Cycles since reset release, saturating
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) up_ff <= '0;
		else if (up_ff != 24'hFFFFFF) up_ff <= up_ff + 24'h1;
	end
	sequence s_wr_end; $rose(WE_N) && !OE_HV; endsequence
	sequence s_clr_end; $rose(WE_N) && OE_HV; endsequence
	chk_strobe_width: assert property (s_wr_end |-> low_ff >= WP_CYC && low_ff <= WP_MAX_CYC)
		else $error("write strobe width out of range");
	chk_clear_width: assert property (s_clr_end |-> low_ff >= CLEAR_CYC)
		else $error("clear strobe too short");
	chk_write_levels: assert property (!WE_N |-> !CS_N && (OE_N || OE_HV))
		else $error("strobe low without select or with output enable");
	chk_addr_hold: assert property (!WE_N && !$past(WE_N) |-> $stable(ADDRESS_LINES))
		else $error("address moved during strobe");
	chk_data_hold: assert property (s_wr_end |-> DATA_PINS_OE && $stable(DATA_PINS_O))
		else $error("data not held to strobe rise");
	chk_no_clash: assert property (!OE_N && !OE_HV |-> !DATA_PINS_OE)
		else $error("host drives data while memory outputs");
	chk_power_lock: assert property ($fell(WE_N) |-> up_ff > PWRUP_CYC)
		else $error("write inside power-up lockout");
	chk_read_window: assert property (RDATA_VALID |-> !$past(CS_N) && !$past(OE_N))
		else $error("read data without read cycle");
	chk_id_addr: assert property (ID_HV && !CS_N |-> ADDRESS_LINES >= ID_BASE)
		else $error("id access outside id range");
	chk_timeout_pair: assert property (TIMEOUT |-> DONE)
		else $error("timeout without done");
endmodule : pepw_host_props

bind pepw_host pepw_host_props #(.PWRUP_CYC(PWRUP_CYC), .CLEAR_CYC(CLEAR_CYC)) u_props (.SYS_CLK, .RST,
	.RDATA_VALID, .DONE, .TIMEOUT, .CS_N, .OE_N, .WE_N, .OE_HV, .ID_HV, .ADDRESS_LINES, .DATA_PINS_O, .DATA_PINS_OE);

/* File: verification/pepw_mem_model.sv */
// Behavioural model of the 8K x 8 page-write memory
module pepw_mem_model
	import pepw_pkg::*;
#(
	parameter int TPLW = 150000,
	parameter int TPU  = 300,
	parameter int TCLR = 1500
) (
	input  wire logic              cs_n,
	input  wire logic              oe_n,
	input  wire logic              we_n,
	input  wire logic              oe_hv,
	input  wire logic              id_hv,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] din,
	output logic                   doe,
	output logic [DATA_W-1:0]      dout
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DATA_W-1:0] mem [ARRAY_DEPTH];
	logic [DATA_W-1:0] idm [PAGE_BYTES];
	logic [DATA_W-1:0] pg [PAGE_BYTES];
	logic [31:0]       ld;
	logic [12:0]       la;
	logic [7:0]        pa, lastd, rd, prv;
	logic              busy, loading, pid;
	int                twc = 1000;
	realtime           tf;
	wire               wr_n = cs_n | we_n;
	// Power-on contents
	initial begin
		busy = 0;
		loading = 0;
		ld = '0;
		foreach (mem[i]) mem[i] = i[7:0] ^ 8'h5A;
		foreach (idm[i]) idm[i] = 8'h00;
	end
	// Address latch on the later falling edge
	always @(negedge wr_n) begin
		tf = $realtime;
		la = addr;
	end
	// Data latch on the first rising edge, filtered and gated
	always @(posedge wr_n) begin
		if ($realtime - tf >= 15 && $realtime >= TPU && !busy && (oe_n || oe_hv)) begin
			if (oe_hv) begin
				if ($realtime - tf >= TCLR) foreach (mem[i]) mem[i] = 8'hFF;
			end else begin
				if (!loading) pid = id_hv;
				if (!loading) pa = la[12:5];
				pg[la[4:0]] = din;
				ld[la[4:0]] = 1'b1;
				lastd = din;
				loading = 1'b1;
			end
		end
	end
	// Load window, then self-timed programming of loaded bytes only
	always begin
		wait (loading);
		#(TPLW);
		busy = 1'b1;
		loading = 1'b0;
		#(twc);
		foreach (pg[i]) if (ld[i] && pid) idm[i] = pg[i];
		foreach (pg[i]) if (ld[i] && !pid) mem[{pa, i[4:0]}] = pg[i];
		ld = '0;
		busy = 1'b0;
	end
	// Read path with polling answer while writing
	assign doe = !cs_n && !oe_n && we_n && !oe_hv;
	always_comb begin
		if (busy || loading) rd = {~lastd[7], lastd[6:0]};
		else if (id_hv && addr >= ID_BASE) rd = idm[addr[4:0]];
		else rd = mem[addr];
	end
	// Released bus shows the inverse of the last value
	always @(negedge doe) prv = rd;
	assign dout = doe ? rd : ~prv;
endmodule : pepw_mem_model

/* File: verification/tb_parallel_eeprom_page_write.sv */
// Self-checking bench of the EEPROM host against the memory model
module tb_parallel_eeprom_page_write import pepw_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic SYS_CLK = 0, RST = 1, REQ_VALID = 0, WDATA_VALID = 0;
	logic REQ_READY, WDATA_READY, RDATA_VALID, DONE, TIMEOUT, CS_N, OE_N, WE_N, OE_HV, ID_HV, DATA_PINS_OE, m_doe;
	pepw_req_t REQ = '0;
	logic [7:0] WDATA = '0, RDATA, DATA_PINS_O, DATA_PINS_I, m_dq;
	logic [4:0] WBYTE = '0;
	logic [12:0] ADDRESS_LINES;
	int n_errors = 0, num_checks = 0, cyc = 0;
	pepw_host #(.PLW_CYC(1000), .WC_CYC(2000), .PWRUP_CYC(50), .CLEAR_CYC(200)) u_dut (.SYS_CLK, .RST, .REQ,
		.REQ_VALID, .REQ_READY, .WDATA, .WBYTE, .WDATA_VALID, .WDATA_READY, .RDATA, .RDATA_VALID, .DONE, .TIMEOUT,
		.CS_N, .OE_N, .WE_N, .OE_HV, .ID_HV, .ADDRESS_LINES, .DATA_PINS_O, .DATA_PINS_OE, .DATA_PINS_I);
	pepw_mem_model #(.TPLW(8000)) u_mem (.cs_n(CS_N), .oe_n(OE_N), .we_n(WE_N),
		.oe_hv(OE_HV), .id_hv(ID_HV), .addr(ADDRESS_LINES), .din(DATA_PINS_O), .doe(m_doe), .dout(m_dq));
	assign DATA_PINS_I = DATA_PINS_OE ? DATA_PINS_O : m_dq;
	always #4 SYS_CLK = ~SYS_CLK;
	// Hang guard
	always @(posedge SYS_CLK) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic req(pepw_cmd_t c, logic id, logic [12:0] a, logic [5:0] n);
		@(posedge SYS_CLK);
		REQ <= '{c, id, a, n};
		REQ_VALID <= 1'b1;
		do @(posedge SYS_CLK); while (REQ_READY !== 1'b1);
		REQ_VALID <= 1'b0;
	endtask : req
	task automatic put(logic [4:0] b, logic [7:0] d);
		@(posedge SYS_CLK);
		WBYTE <= b;
		WDATA <= d;
		WDATA_VALID <= 1'b1;
		do @(posedge SYS_CLK); while (WDATA_READY !== 1'b1);
		WDATA_VALID <= 1'b0;
	endtask : put
	task automatic fin(logic to);
		do @(posedge SYS_CLK); while (DONE !== 1'b1);
		chk("timeout flag", {7'h0, to}, {7'h0, TIMEOUT});
	endtask : fin
	task automatic rd(logic id, logic [12:0] a, logic [7:0] e);
		req(PEPW_CMD_READ, id, a, 6'h01);
		do @(posedge SYS_CLK); while (RDATA_VALID !== 1'b1);
		chk("read data", e, RDATA);
	endtask : rd
	task automatic t_page();
		u_mem.twc = 6000;
		req(PEPW_CMD_PAGE, 1'b0, 13'h0420, 6'h03);
		put(5'h1F, 8'h11);
		put(5'h00, 8'h22);
		put(5'h1F, 8'h93);
		fin(1'b0);
		rd(1'b0, 13'h043F, 8'h93);
		rd(1'b0, 13'h0420, 8'h22);
		rd(1'b0, 13'h0425, 8'h7F);
	endtask : t_page
	task automatic t_full();
		u_mem.twc = 500;
		req(PEPW_CMD_PAGE, 1'b0, 13'h1C00, 6'h20);
		for (int i = 31; i >= 0; i--) put(i[4:0], 8'h81 ^ i[7:0]);
		fin(1'b0);
		for (int i = 0; i < 32; i += 15) rd(1'b0, 13'h1C00 | i[12:0], 8'h81 ^ i[7:0]);
	endtask : t_full
	task automatic t_plw();
		u_mem.twc = 500;
		req(PEPW_CMD_PAGE, 1'b0, 13'h0200, 6'h02);
		put(5'h04, 8'h66);
		fin(1'b0);
		chk("load ready after window", 8'h00, {7'h0, WDATA_READY});
		rd(1'b0, 13'h0204, 8'h66);
		rd(1'b0, 13'h0205, 8'h5F);
	endtask : t_plw
	task automatic t_tmo();
		u_mem.twc = 30000;
		req(PEPW_CMD_PAGE, 1'b0, 13'h0100, 6'h01);
		put(5'h02, 8'h0F);
		fin(1'b1);
		wait (u_mem.busy === 1'b0);
		rd(1'b0, 13'h0102, 8'h0F);
	endtask : t_tmo
	task automatic t_clear();
		req(PEPW_CMD_CLEAR, 1'b0, 13'h0000, 6'h01);
		fin(1'b0);
		rd(1'b0, 13'h0420, 8'hFF);
		rd(1'b0, 13'h1FE3, 8'hFF);
	endtask : t_clear
	task automatic t_id();
		u_mem.twc = 500;
		req(PEPW_CMD_PAGE, 1'b1, 13'h0000, 6'h00);
		put(5'h03, 8'h3C);
		fin(1'b0);
		rd(1'b1, 13'h0003, 8'h3C);
		rd(1'b0, 13'h1FE3, 8'hFF);
	endtask : t_id
	// Main sequence
	initial begin
		repeat (12) @(posedge SYS_CLK);
		RST <= 1'b0;
		repeat (2) @(posedge SYS_CLK);
		chk("ready in lockout", 8'h00, {7'h0, REQ_READY});
		rd(1'b0, 13'h0000, 8'h5A);
		rd(1'b0, 13'h1FFF, 8'hA5);
		t_page();
		t_full();
		t_plw();
		t_tmo();
		t_clear();
		t_id();
		end_of_test();
	end
endmodule : tb_parallel_eeprom_page_write
